// *** branch_jump_control.sv ***
`timescale 1ns/100ps
module branch_jump_control (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic start,
  input wire bjc_pkg::op_t op,
  input wire bjc_pkg::cond_t cond,
  input wire logic [7:0] disp,
  input wire logic [15:0] abs_addr,
  input wire logic [7:0] mem_addr,
  input wire logic [15:0] reg_value,
  input wire logic [3:0] ccr_nzvc,
  input wire logic [15:0] mem_rdata,
  output logic [15:0] pc,
  output logic [15:0] sp,
  output logic mem_rd,
  output logic [15:0] mem_addr_out,
  output logic mem_wr,
  output logic [15:0] mem_wdata,
  output logic busy,
  output logic done
);
  import bjc_pkg::*;

  // ------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------
  // Combinational; its answer only counts at the take edge
  flag_if fl ();
  cond_eval u_eval (.fl(fl));

  logic [3:0] flags;
  op_t cur_op;
  logic [7:0] cur_disp;
  logic [15:0] cur_abs;
  logic [7:0] cur_maddr;
  logic [15:0] cur_reg;
  logic [3:0] cnt;
  logic [3:0] len;
  logic taken_q;

  typedef enum logic [0:0] {IDLE, EXEC} state_t;
  state_t state;

  // RL9 flags sampled at start
  assign fl.n = flags[3];
  assign fl.z = flags[2];
  assign fl.v = flags[1];
  assign fl.c = flags[0];
  assign fl.cond = cond;

  function automatic logic [15:0] rel_target(input logic [15:0] p,
                                             input logic [7:0] d);
    // Displacement is relative to the following instruction
    rel_target = p + INSN_STEP + {{8{d[7]}}, d};
  endfunction : rel_target

  // State count per operation; the sequencer stops when it is reached
  function automatic logic [3:0] op_len(input op_t o);
    case (o)
      // RL1 branch states
      OP_BRANCH: op_len = 4'(BRANCH_STATES);
      // RL3 register jump states
      OP_JMP_REG: op_len = 4'(JMP_REG_STATES);
      // RL4 absolute jump states
      OP_JMP_ABS: op_len = 4'(JMP_ABS_STATES);
      // RL5 memory jump states
      OP_JMP_MEM: op_len = 4'(JMP_MEM_STATES);
      // RL6 call states
      OP_CALL: op_len = 4'(CALL_STATES);
      default: op_len = 4'(BRANCH_STATES);
    endcase
  endfunction : op_len

  assign flags = ccr_nzvc;

  // ------------------------------------------------------------
  // State decoding shared by the update processes
  // ------------------------------------------------------------
  // Memory traffic sits in one fixed state, well before the last one,
  // so the push or fetch never collides with the pc update.
  function automatic logic in_access(input state_t s,
                                     input logic [3:0] c);
    in_access = (s == EXEC) && (c == 4'(ACCESS_STATE));
  endfunction : in_access

  function automatic logic in_last(input state_t s,
                                   input logic [3:0] c,
                                   input logic [3:0] l);
    in_last = (s == EXEC) && (c == l);
  endfunction : in_last

  logic access_now;
  logic last_now;

  assign access_now = in_access(state, cnt);
  assign last_now = in_last(state, cnt, len);

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= IDLE;
      cnt <= 4'h0;
      len <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      cur_op <= OP_BRANCH;
      cur_disp <= 8'h00;
      cur_abs <= 16'h0000;
      cur_maddr <= 8'h00;
      cur_reg <= 16'h0000;
      taken_q <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      case (state)
        IDLE: begin
          // A request while busy never reaches here and is simply lost
          if (start) begin
            state <= EXEC;
            busy <= 1'b1;
            cnt <= 4'h1;
            len <= op_len(op);
            // Operands are latched so the requester may change them at once
            cur_op <= op;
            cur_disp <= disp;
            cur_abs <= abs_addr;
            cur_maddr <= mem_addr;
            cur_reg <= reg_value;
            taken_q <= fl.taken;
          end
        end
        EXEC: begin
          // The longest sequence is 8 states, inside the 4-bit counter
          cnt <= cnt + 4'h1;
          if (last_now) begin
            state <= IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Memory port: indirect word fetch and return address push
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr_out <= 16'h0000;
      mem_wdata <= 16'h0000;
    end else if (ce) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      // Address and data stand until the next access for a slow memory
      if (access_now) begin
        if (cur_op == OP_JMP_MEM) begin
          // RL5 indirect read
          mem_rd <= 1'b1;
          mem_addr_out <= {8'h00, cur_maddr};
        end else if (cur_op == OP_CALL) begin
          // RL6 push return address
          mem_wr <= 1'b1;
          mem_addr_out <= sp - SP_STEP;
          mem_wdata <= pc + INSN_STEP;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Stack pointer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sp <= SP_RESET;
    end else if (ce) begin
      // Moves in the push state, so the written address is the new top
      // RL6 stack decrement
      if (access_now && cur_op == OP_CALL) begin
        sp <= sp - SP_STEP;
      end
    end
  end

  // ------------------------------------------------------------
  // Program counter, updated on the last state
  // ------------------------------------------------------------
  // Memory data is sampled on the last state, so the read latency may be
  // up to several cycles without extra handshaking.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pc <= PC_RESET;
    end else if (ce && last_now) begin
      case (cur_op)
        OP_BRANCH: begin
          // RL7 taken or next
          // RL9 untaken continues
          if (taken_q) begin
            pc <= rel_target(pc, cur_disp);
          end else begin
            pc <= pc + INSN_STEP;
          end
        end
        // RL3 register target
        OP_JMP_REG: pc <= cur_reg;
        // RL4 absolute target
        OP_JMP_ABS: pc <= cur_abs;
        // RL5 loaded word
        OP_JMP_MEM: pc <= mem_rdata;
        // RL6 relative call
        OP_CALL: pc <= rel_target(pc, cur_disp);
        default: pc <= pc;
      endcase
    end
  end
endmodule : branch_jump_control

// *** bjc_pkg.sv ***
// Functional notes
// RL1: Signed ge/lt branch on N xor V; conditional branches take 4 states.
// RL2: V and N single-flag tests; greater-than/less-or-equal use Z or (N xor V).
// RL3: Register-indirect jump loads full 16-bit register; 4 states.
// RL4: Absolute jump loads 16-bit address from instruction; 6 states.
// RL5: Memory-indirect jump reads word at 8-bit address; 8 states.
// RL6: Subroutine branch: SP minus 2, push PC, add displacement; 6 states.
// RL7: Never-taken advances PC by two; always-taken adds displacement.
// RL8: Higher/lower-or-same use C or Z; carry and equal tests single flag.
// RL9: Flags from last completed instruction; untaken branch goes to next.
package bjc_pkg;
  localparam int BRANCH_STATES = 4;
  localparam int JMP_REG_STATES = 4;
  localparam int JMP_ABS_STATES = 6;
  localparam int JMP_MEM_STATES = 8;
  localparam int CALL_STATES = 6;
  localparam int ACCESS_STATE = 2;
  localparam logic [15:0] INSN_STEP = 16'h0002;
  localparam logic [15:0] SP_STEP = 16'h0002;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;

  typedef enum logic [3:0] {
    COND_ALWAYS, COND_NEVER, COND_HI, COND_LS, COND_CC, COND_CS,
    COND_NE, COND_EQ, COND_VC, COND_VS, COND_PL, COND_MI,
    COND_GE, COND_LT, COND_GT, COND_LE
  } cond_t;

  typedef enum logic [2:0] {
    OP_BRANCH, OP_JMP_REG, OP_JMP_ABS, OP_JMP_MEM, OP_CALL
  } op_t;
endpackage : bjc_pkg

// *** flag_if.sv ***
`timescale 1ns/100ps
interface flag_if;
  logic n;
  logic z;
  logic v;
  logic c;
  bjc_pkg::cond_t cond;
  logic taken;
  modport eval (input n, z, v, c, cond, output taken);
  modport user (output n, z, v, c, cond, input taken);
endinterface : flag_if

// *** cond_eval.sv ***
`timescale 1ns/100ps
module cond_eval (
  flag_if.eval fl
);
  import bjc_pkg::*;
  always_comb begin
    case (fl.cond)
      // RL7 always and never
      COND_ALWAYS: fl.taken = 1'b1;
      COND_NEVER: fl.taken = 1'b0;
      // RL8 carry or zero
      COND_HI: fl.taken = ~(fl.c | fl.z);
      COND_LS: fl.taken = fl.c | fl.z;
      COND_CC: fl.taken = ~fl.c;
      COND_CS: fl.taken = fl.c;
      COND_NE: fl.taken = ~fl.z;
      COND_EQ: fl.taken = fl.z;
      // RL2 single flag tests
      COND_VC: fl.taken = ~fl.v;
      COND_VS: fl.taken = fl.v;
      COND_PL: fl.taken = ~fl.n;
      COND_MI: fl.taken = fl.n;
      // RL1 signed compare
      COND_GE: fl.taken = ~(fl.n ^ fl.v);
      COND_LT: fl.taken = fl.n ^ fl.v;
      // RL2 signed greater
      COND_GT: fl.taken = ~(fl.z | (fl.n ^ fl.v));
      COND_LE: fl.taken = fl.z | (fl.n ^ fl.v);
      default: fl.taken = 1'b0;
    endcase
  end
endmodule : cond_eval

// *** bjc_sva.sv ***
`timescale 1ns/100ps
// ----
// Checker
// ----
module bjc_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic start,
  input wire bjc_pkg::op_t op,
  input wire bjc_pkg::cond_t cond,
  input wire logic [7:0] disp,
  input wire logic [15:0] abs_addr,
  input wire logic [7:0] mem_addr,
  input wire logic [15:0] reg_value,
  input wire logic [15:0] mem_rdata,
  input wire logic [15:0] pc,
  input wire logic [15:0] sp,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_wr,
  input wire logic [15:0] mem_wdata,
  input wire logic busy,
  input wire logic done
);
  import bjc_pkg::*;
  wire go = start && !busy && ce;
  wire [15:0] sx = {{8{disp[7]}}, disp};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rst;
    disable iff (1'b0) !rst_b |=> pc == 16'h0000 && sp == 16'h0000 && !busy;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_br;
    go && op == OP_BRANCH |-> ##4 !done ##1 done;
  endproperty
  a_br: assert property (p_br) else $error("branch length");
  property p_nev;
    go && op == OP_BRANCH && cond == COND_NEVER |->
      ##5 pc == $past(pc, 5) + INSN_STEP;
  endproperty
  a_nev: assert property (p_nev) else $error("never branch");
  property p_alw;
    go && op == OP_BRANCH && cond == COND_ALWAYS |->
      ##5 pc == $past(pc, 5) + INSN_STEP + $past(sx, 5);
  endproperty
  a_alw: assert property (p_alw) else $error("always branch");
  property p_reg;
    go && op == OP_JMP_REG |-> ##5 done && pc == $past(reg_value, 5);
  endproperty
  a_reg: assert property (p_reg) else $error("register jump");
  property p_abs;
    go && op == OP_JMP_ABS |-> ##7 done && pc == $past(abs_addr, 7);
  endproperty
  a_abs: assert property (p_abs) else $error("absolute jump");
  property p_mem;
    go && op == OP_JMP_MEM |-> ##3 mem_rd && mem_addr_out ==
      {8'h00, $past(mem_addr, 3)} ##6 done && pc == $past(mem_rdata);
  endproperty
  a_mem: assert property (p_mem) else $error("memory jump");
  property p_call;
    go && op == OP_CALL |-> ##3 mem_wr && sp == $past(sp, 3) - SP_STEP
      && mem_addr_out == sp && mem_wdata == $past(pc, 3) + INSN_STEP
      ##4 done && pc == $past(pc, 7) + INSN_STEP + $past(sx, 7);
  endproperty
  a_call: assert property (p_call) else $error("subroutine call");
  property p_pulse;
    done |-> !busy ##1 !done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse");
endmodule : bjc_sva

// *** tb_branch_jump_control.sv ***
`timescale 1ns/100ps
module tb_branch_jump_control;
  import bjc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  // Low only while idle: the checker counts states as clock cycles
  logic ce = 1'b1;
  logic start = 1'b0;
  op_t op = OP_BRANCH;
  cond_t cond = COND_ALWAYS;
  logic [7:0] disp = 8'hf0;
  logic [15:0] abs_addr = 16'hbeef;
  logic [7:0] mem_addr = 8'h5a;
  logic [15:0] reg_value = 16'h1234;
  logic [3:0] ccr_nzvc = 4'h0;
  logic [15:0] mem_rdata = 16'h4321;
  logic [15:0] pc, sp, mem_addr_out, mem_wdata;
  logic mem_rd, mem_wr, busy, done;
  logic [15:0] exp_pc = 16'h0000;
  int fail_count = 0;
  int cmp_count = 0;
  // ----
  // Rows: {N,Z,V,C} then taken; two per cond_t value, index modulo 16
  // ----
  logic [4:0] rows [32] = '{5'h01, 5'h1e, 5'h01, 5'h03, 5'h02, 5'h03,
    5'h08, 5'h09, 5'h04, 5'h05, 5'h10, 5'h11, 5'h15, 5'h11, 5'h1c, 5'h05,
    5'h1f, 5'h00, 5'h08, 5'h00, 5'h01, 5'h1c, 5'h01, 5'h16,
    5'h01, 5'h1a, 5'h01, 5'h0e, 5'h10, 5'h14, 5'h15, 5'h14};
  always #12.5 clk = ~clk;
  branch_jump_control i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .start(start),
    .op(op),
    .cond(cond),
    .disp(disp),
    .abs_addr(abs_addr),
    .mem_addr(mem_addr),
    .reg_value(reg_value),
    .ccr_nzvc(ccr_nzvc),
    .mem_rdata(mem_rdata),
    .pc(pc),
    .sp(sp),
    .mem_rd(mem_rd),
    .mem_addr_out(mem_addr_out),
    .mem_wr(mem_wr),
    .mem_wdata(mem_wdata),
    .busy(busy),
    .done(done)
  );
  task report_and_stop;
    $display("checks %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input string name, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  // Start stays up one cycle into busy, so a refused request is exercised
  task automatic run(input op_t o, input int n);
    int k;
    op = o;
    start = 1'b1;
    @(posedge clk);
    @(negedge clk);
    ccr_nzvc = ~ccr_nzvc;
    k = 0;
    repeat (20) if (done !== 1'b1) begin
      @(posedge clk);
      @(negedge clk);
      start = 1'b0;
      k++;
    end
    if (done !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    chk("states", 16'(n), 16'(k));
  endtask : run
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    chk("pc", 16'h0000, pc);
    chk("sp", 16'h0000, sp);
    for (int i = 0; i < 32; i++) begin
      cond = cond_t'(i[3:0]);
      ccr_nzvc = rows[i][4:1];
      exp_pc += rows[i][0] ? 16'hfff2 : 16'h0002;
      run(OP_BRANCH, 4);
      chk("pc", exp_pc, pc);
    end
    run(OP_JMP_REG, 4);
    chk("pc", 16'h1234, pc);
    run(OP_JMP_ABS, 6);
    chk("pc", 16'hbeef, pc);
    run(OP_JMP_MEM, 8);
    chk("pc", 16'h4321, pc);
    disp = 8'h7f;
    run(OP_CALL, 6);
    chk("pc", 16'h43a2, pc);
    chk("sp", 16'hfffe, sp);
    // Reset in mid-call, after the push; first request right at release
    op = OP_CALL;
    start = 1'b1;
    repeat (3) @(negedge clk);
    start = 1'b0;
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    chk("pc", 16'h0000, pc);
    chk("sp", 16'h0000, sp);
    chk("busy", 16'h0000, 16'(busy));
    chk("mem_wr", 16'h0000, 16'(mem_wr));
    cond = COND_ALWAYS;
    run(OP_BRANCH, 4);
    chk("pc", 16'h0081, pc);
    // Enable low: a request is not taken and nothing moves
    @(negedge clk);
    ce = 1'b0;
    op = OP_JMP_ABS;
    start = 1'b1;
    repeat (3) @(negedge clk);
    chk("busy", 16'h0000, 16'(busy));
    chk("pc", 16'h0081, pc);
    start = 1'b0;
    ce = 1'b1;
    report_and_stop();
  end
endmodule : tb_branch_jump_control
bind branch_jump_control bjc_sva i_sva (
  .clk(clk),
  .rst_b(rst_b),
  .ce(ce),
  .start(start),
  .op(op),
  .cond(cond),
  .disp(disp),
  .abs_addr(abs_addr),
  .mem_addr(mem_addr),
  .reg_value(reg_value),
  .mem_rdata(mem_rdata),
  .pc(pc),
  .sp(sp),
  .mem_rd(mem_rd),
  .mem_addr_out(mem_addr_out),
  .mem_wr(mem_wr),
  .mem_wdata(mem_wdata),
  .busy(busy),
  .done(done)
);
